// ==== hdl/pmc_defines.svh ====
// Offsets, field positions, reset values and timing figures of the power control block.
// Assumes a 200 MHz system clock and a byte-addressed 32-bit register bus.
`ifndef PMC_DEFINES_SVH
`define PMC_DEFINES_SVH

`define PMC_ADR_W           8
`define PMC_CTL_OFS         8'h14
`define PMC_WAKE_CAUSE_OFS  8'h18

`define PMC_BIT_SKIP_WAIT   15
`define PMC_BIT_XTAL_KEEP   14
`define PMC_BIT_EEE_EN      13
`define PMC_BIT_EEE_STS     12
`define PMC_BIT_MAC_DOMAIN_SOFT_RESET    11
`define PMC_BIT_CLR_STS     9
`define PMC_BIT_CLR_EN      8
`define PMC_BIT_READY       7
`define PMC_SUSP_HI         6
`define PMC_SUSP_LO         5
`define PMC_CAUSE_PHY       0
`define PMC_CAUSE_FRAME     1

`define PMC_RST_SKIP_WAIT   1'b0
`define PMC_RST_XTAL_KEEP   1'b0
`define PMC_RST_CLR_STS     1'b0
`define PMC_RST_CLR_EN      1'b1
`define PMC_RST_SUSP        2'h2

`define PMC_CLK_PERIOD_NS   5
`define PMC_PHY_HOLD_NS     4000000
`define PMC_REF_SETTLE_NS   100000000
`define PMC_REF_HOLD_NS     128000000
`define PMC_CLK_IDLE_CYC    16

`endif

// ==== hdl/pmc_pkg.sv ====
// Types shared by the power management control block.
// Assumes nothing beyond a SystemVerilog compiler.
package pmc_pkg;

  typedef logic [1:0] pmc_sleep_t;

  typedef enum logic [1:0]
  {
    pmc_sleep_0,
    pmc_sleep_1,
    pmc_sleep_2,
    pmc_sleep_3
  } pmc_sleep_level_t;

  typedef enum logic [1:0]
  {
    pmc_phy_idle,
    pmc_phy_hold,
    pmc_phy_settle
  } pmc_phy_state_t;

endpackage : pmc_pkg

// ==== hdl/pmc_clk_monitor.sv ====
// Clock activity monitor: reports whether a foreign clock is toggling.
// Assumes the watched clock is slower than half of clk_i; it is sampled as a plain input.
`timescale 1ns/10ps
`default_nettype none

`include "pmc_defines.svh"

module pmc_clk_monitor
#(
  parameter int unsigned IDLE_CYC = `PMC_CLK_IDLE_CYC
)
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic mon_clk_i,
  output var  logic active_o
);
  import pmc_pkg::*;

  localparam int unsigned CW = $clog2(IDLE_CYC + 1);

  logic          sync1_ff;
  logic          sync2_ff;
  logic          last_ff;
  logic [CW-1:0] idle_cnt_ff;

  if (IDLE_CYC < 2)
  begin : g_bad_idle
    $error("pmc_clk_monitor: IDLE_CYC must be at least 2");
  end

  // Two-stage synchroniser; only the second stage feeds the edge detector.
  always_ff @(posedge clk_i)
  begin
    sync1_ff <= mon_clk_i;
    sync2_ff <= sync1_ff;
    last_ff  <= sync2_ff;
  end

  // Counts cycles since the last seen edge and saturates at the idle window.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      idle_cnt_ff <= CW'(IDLE_CYC);
      active_o    <= 1'b0;
    end
    else if (sync2_ff != last_ff)
    begin
      idle_cnt_ff <= '0;
      active_o    <= 1'b1;
    end
    else if (idle_cnt_ff != CW'(IDLE_CYC))
    begin
      idle_cnt_ff <= idle_cnt_ff + CW'(1);
    end
    else
    begin
      active_o <= 1'b0;
    end
  end

endmodule : pmc_clk_monitor

`default_nettype wire

// ==== hdl/pmc_power_mgmt_control.sv ====
// Power management control register with PHY reset sequencing and wake bookkeeping.
// Assumes a classic Wishbone master on clk_i and event inputs synchronous to clk_i.
//
// The Wishbone register port was decided locally.
`timescale 1ns/10ps
`default_nettype none

`include "pmc_defines.svh"

module pmc_power_mgmt_control
#(
  parameter int unsigned HOLD_CYC       = `PMC_PHY_HOLD_NS / `PMC_CLK_PERIOD_NS,
  parameter int unsigned REF_SETTLE_CYC = `PMC_REF_SETTLE_NS / `PMC_CLK_PERIOD_NS,
  parameter int unsigned REF_HOLD_CYC   = `PMC_REF_HOLD_NS / `PMC_CLK_PERIOD_NS,
  parameter int unsigned IDLE_CYC       = `PMC_CLK_IDLE_CYC
)
(
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   protected_reset_i,
  input  wire logic                   cyc_i,
  input  wire logic                   stb_i,
  input  wire logic                   we_i,
  input  wire logic [`PMC_ADR_W-1:0]  adr_i,
  input  wire logic [3:0]             sel_i,
  input  wire logic [31:0]            dat_i,
  output var  logic [31:0]            dat_o,
  output var  logic                   ack_o,
  input  wire logic                   phy_reset_start_i,
  input  wire logic                   config_loading_i,
  input  wire logic                   deep_suspend_i,
  input  wire logic                   unconfigured_i,
  input  wire logic                   eee_wake_event_i,
  input  wire logic                   phy_wake_event_i,
  input  wire logic                   frame_wake_event_i,
  input  wire logic                   resume_done_i,
  input  wire logic                   resume_by_host_i,
  input  wire logic                   mac_rx_clk_i,
  input  wire logic                   mac_tx_clk_i,
  output var  logic                   ethernet_phy_reset_o,
  output var  logic                   analog_ref_on_o,
  output var  logic                   crystal_enable_o,
  output var  logic                   mac_rx_reset_o,
  output var  logic                   mac_tx_reset_o,
  output var  logic                   wake_request_o,
  output var  logic                   wake_status_clear_o,
  output var  logic                   wake_enable_clear_o,
  output var  pmc_pkg::pmc_sleep_t    sleep_level_o
);
  import pmc_pkg::*;

  if (HOLD_CYC < 1 || REF_HOLD_CYC < HOLD_CYC + REF_SETTLE_CYC || REF_SETTLE_CYC < 1)
  begin : g_bad_timing
    $error("pmc_power_mgmt_control: PHY reset timing parameters are inconsistent");
  end

  localparam logic [31:0] HOLD_LAST   = 32'(HOLD_CYC - 1);
  localparam logic [31:0] SETTLE_LAST = 32'(REF_HOLD_CYC - HOLD_CYC - 1);

  function automatic logic reg_hit(input logic [`PMC_ADR_W-1:0] adr,
                                   input logic [`PMC_ADR_W-1:0] ofs);
    reg_hit = (adr[`PMC_ADR_W-1:2] == ofs[`PMC_ADR_W-1:2]);
  endfunction : reg_hit

  logic           ack_ff;
  logic           req;
  logic           wr_ctl_lo;
  logic           wr_ctl_hi;
  logic           wr_cause;
  logic           remote_resume;

  logic           skip_wait_ff;
  logic           xtal_keep_ff;
  logic           eee_en_ff;
  logic           eee_sts_ff;
  logic           mac_domain_soft_reset_ff;
  logic           clr_sts_ff;
  logic           clr_en_ff;
  logic           ready_ff;
  pmc_sleep_t     susp_ff;
  logic [1:0]     cause_ff;
  logic [31:0]    rdata;

  pmc_phy_state_t state_ff;
  pmc_phy_state_t nxt_state;
  logic [31:0]    cnt_ff;
  logic [31:0]    nxt_cnt;

  logic           rx_active;
  logic           tx_active;

  // Bus request decode: each request is taken once, on the edge that raises ack.
  assign req       = cyc_i & stb_i & ~ack_ff;
  assign wr_ctl_lo = req & we_i & sel_i[0] & reg_hit(adr_i, `PMC_CTL_OFS);
  assign wr_ctl_hi = req & we_i & sel_i[1] & reg_hit(adr_i, `PMC_CTL_OFS);
  assign wr_cause  = req & we_i & sel_i[0] & reg_hit(adr_i, `PMC_WAKE_CAUSE_OFS);

  // Only resumes caused by a device wake event trigger automatic clearing.
  assign remote_resume = resume_done_i & ~resume_by_host_i;

  // Read multiplexer; reserved and unmapped positions read zero.
  always_comb
  begin
    rdata = '0;
    if (reg_hit(adr_i, `PMC_CTL_OFS))
    begin
      rdata[`PMC_BIT_SKIP_WAIT]            = skip_wait_ff;
      rdata[`PMC_BIT_XTAL_KEEP]            = xtal_keep_ff;
      rdata[`PMC_BIT_EEE_EN]               = eee_en_ff;
      rdata[`PMC_BIT_EEE_STS]              = eee_sts_ff;
      rdata[`PMC_BIT_MAC_DOMAIN_SOFT_RESET]             = mac_domain_soft_reset_ff;
      rdata[`PMC_BIT_CLR_STS]              = clr_sts_ff;
      rdata[`PMC_BIT_CLR_EN]               = clr_en_ff;
      rdata[`PMC_BIT_READY]                = ready_ff;
      rdata[`PMC_SUSP_HI:`PMC_SUSP_LO]     = susp_ff;
    end
    else if (reg_hit(adr_i, `PMC_WAKE_CAUSE_OFS))
    begin
      rdata[`PMC_CAUSE_FRAME:`PMC_CAUSE_PHY] = cause_ff;
    end
  end

  // Wishbone slave: ack one cycle after the request, dropped the cycle after.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_ff <= 1'b0;
      dat_o  <= '0;
    end
    else
    begin
      ack_ff <= req;
      if (req & ~we_i)
      begin
        dat_o <= rdata;
      end
    end
  end

  assign ack_o = ack_ff;

  // Protected fields: only the full reset returns them to defaults.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      skip_wait_ff <= `PMC_RST_SKIP_WAIT;
      xtal_keep_ff <= `PMC_RST_XTAL_KEEP;
    end
    else if (wr_ctl_hi)
    begin
      skip_wait_ff <= dat_i[`PMC_BIT_SKIP_WAIT];
      xtal_keep_ff <= dat_i[`PMC_BIT_XTAL_KEEP];
    end
  end

  // Plain control bits, returned to defaults by any reset.
  always_ff @(posedge clk_i)
  begin
    if (rst_i | protected_reset_i)
    begin
      mac_domain_soft_reset_ff <= 1'b0;
      clr_sts_ff  <= `PMC_RST_CLR_STS;
      clr_en_ff   <= `PMC_RST_CLR_EN;
    end
    else
    begin
      if (wr_ctl_hi)
      begin
        mac_domain_soft_reset_ff <= dat_i[`PMC_BIT_MAC_DOMAIN_SOFT_RESET];
        clr_sts_ff  <= dat_i[`PMC_BIT_CLR_STS];
        clr_en_ff   <= dat_i[`PMC_BIT_CLR_EN];
      end
    end
  end

  // Energy efficient wake enable; a remote resume clear overrides a write.
  always_ff @(posedge clk_i)
  begin
    if (rst_i | protected_reset_i)
    begin
      eee_en_ff <= 1'b0;
    end
    else if (remote_resume & clr_en_ff)
    begin
      eee_en_ff <= 1'b0;
    end
    else if (wr_ctl_hi)
    begin
      eee_en_ff <= dat_i[`PMC_BIT_EEE_EN];
    end
  end

  // Energy efficient wake status; a new event wins over any clear.
  always_ff @(posedge clk_i)
  begin
    if (rst_i | protected_reset_i)
    begin
      eee_sts_ff <= 1'b0;
    end
    else if (eee_wake_event_i)
    begin
      eee_sts_ff <= 1'b1;
    end
    else if (remote_resume & clr_sts_ff)
    begin
      eee_sts_ff <= 1'b0;
    end
    else if (wr_ctl_hi & dat_i[`PMC_BIT_EEE_STS])
    begin
      eee_sts_ff <= 1'b0;
    end
  end

  // Wake cause bits: set by events, cleared per bit by writing one.
  always_ff @(posedge clk_i)
  begin
    if (rst_i | protected_reset_i)
    begin
      cause_ff <= 2'h0;
    end
    else
    begin
      if (phy_wake_event_i)
      begin
        cause_ff[`PMC_CAUSE_PHY] <= 1'b1;
      end
      else if (wr_cause & dat_i[`PMC_CAUSE_PHY])
      begin
        cause_ff[`PMC_CAUSE_PHY] <= 1'b0;
      end
      if (frame_wake_event_i)
      begin
        cause_ff[`PMC_CAUSE_FRAME] <= 1'b1;
      end
      else if (remote_resume & clr_sts_ff)
      begin
        cause_ff[`PMC_CAUSE_FRAME] <= 1'b0;
      end
      else if (wr_cause & dat_i[`PMC_CAUSE_FRAME])
      begin
        cause_ff[`PMC_CAUSE_FRAME] <= 1'b0;
      end
    end
  end

  // Suspend selection; losing configuration forces level two.
  always_ff @(posedge clk_i)
  begin
    if (rst_i | protected_reset_i)
    begin
      susp_ff <= `PMC_RST_SUSP;
    end
    else if (unconfigured_i)
    begin
      susp_ff <= `PMC_RST_SUSP;
    end
    else if (wr_ctl_lo)
    begin
      susp_ff <= dat_i[`PMC_SUSP_HI:`PMC_SUSP_LO];
    end
  end

  // Sleep level driven out, with levels zero and one merged.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sleep_level_o <= `PMC_RST_SUSP;
    end
    else if (susp_ff == pmc_sleep_1)
    begin
      sleep_level_o <= pmc_sleep_0;
    end
    else
    begin
      sleep_level_o <= susp_ff;
    end
  end

  // Wake request and clear strobes toward the wake detectors.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wake_request_o      <= 1'b0;
      wake_status_clear_o <= 1'b0;
      wake_enable_clear_o <= 1'b0;
    end
    else
    begin
      wake_request_o      <= eee_en_ff & eee_sts_ff;
      wake_status_clear_o <= remote_resume & clr_sts_ff;
      wake_enable_clear_o <= remote_resume & clr_en_ff;
    end
  end

  // PHY reset sequencer: hold, then optional reference settle.
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff + 32'h1;
    case (state_ff)
      pmc_phy_idle:
      begin
        nxt_cnt = '0;
        if (phy_reset_start_i)
        begin
          nxt_state = pmc_phy_hold;
        end
      end
      pmc_phy_hold:
      begin
        if (cnt_ff == HOLD_LAST)
        begin
          nxt_cnt   = '0;
          nxt_state = skip_wait_ff ? pmc_phy_idle : pmc_phy_settle;
        end
      end
      pmc_phy_settle:
      begin
        if (cnt_ff == SETTLE_LAST)
        begin
          nxt_cnt   = '0;
          nxt_state = pmc_phy_idle;
        end
      end
      default:
      begin
        nxt_cnt   = '0;
        nxt_state = pmc_phy_idle;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_ff <= pmc_phy_hold;
      cnt_ff   <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  // PHY reset, analog reference and ready outputs.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ethernet_phy_reset_o <= 1'b1;
      analog_ref_on_o      <= 1'b0;
      ready_ff             <= 1'b0;
    end
    else
    begin
      ethernet_phy_reset_o <= (nxt_state == pmc_phy_hold);
      analog_ref_on_o      <= (nxt_state != pmc_phy_hold) | skip_wait_ff;
      ready_ff             <= (nxt_state == pmc_phy_idle) & ~config_loading_i;
    end
  end

  // Crystal gating.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      crystal_enable_o <= 1'b1;
    end
    else
    begin
      crystal_enable_o <= xtal_keep_ff | ~deep_suspend_i;
    end
  end

  pmc_clk_monitor
  #(
    .IDLE_CYC (IDLE_CYC)
  )
  u_rx_mon
  (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .mon_clk_i (mac_rx_clk_i),
    .active_o  (rx_active)
  );

  pmc_clk_monitor
  #(
    .IDLE_CYC (IDLE_CYC)
  )
  u_tx_mon
  (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .mon_clk_i (mac_tx_clk_i),
    .active_o  (tx_active)
  );

  // MAC domain resets: held by the soft reset bit or a silent clock.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mac_rx_reset_o <= 1'b1;
      mac_tx_reset_o <= 1'b1;
    end
    else
    begin
      mac_rx_reset_o <= mac_domain_soft_reset_ff | ~rx_active;
      mac_tx_reset_o <= mac_domain_soft_reset_ff | ~tx_active;
    end
  end

endmodule : pmc_power_mgmt_control

`default_nettype wire

// ==== testbench/pmc_power_mgmt_control_props.sv ====
// Concurrent checks on the ports of the power management control block.
// Assumes a bench that shortens HOLD_CYC to 8 and IDLE_CYC to 4.
`timescale 1ns/10ps
`default_nettype none
`include "pmc_defines.svh"
module pmc_props
(
  input wire logic                  clk_i,
  input wire logic                  rst_i,
  input wire logic                  cyc_i,
  input wire logic                  stb_i,
  input wire logic                  we_i,
  input wire logic [`PMC_ADR_W-1:0] adr_i,
  input wire logic [3:0]            sel_i,
  input wire logic [31:0]           dat_i,
  input wire logic [31:0]           dat_o,
  input wire logic                  ack_o,
  input wire logic                  phy_reset_start_i,
  input wire logic                  config_loading_i,
  input wire logic                  deep_suspend_i,
  input wire logic                  unconfigured_i,
  input wire logic                  resume_done_i,
  input wire logic                  resume_by_host_i,
  input wire logic                  mac_rx_clk_i,
  input wire logic                  ethernet_phy_reset_o,
  input wire logic                  analog_ref_on_o,
  input wire logic                  crystal_enable_o,
  input wire logic                  mac_rx_reset_o,
  input wire logic                  mac_tx_reset_o,
  input wire logic                  wake_status_clear_o,
  input wire logic                  wake_enable_clear_o,
  input wire pmc_pkg::pmc_sleep_t   sleep_level_o
);
  import pmc_pkg::*;
  logic       skip_ff;
  logic       xtal_ff;
  logic       rxq_ff;
  logic [3:0] idle_ff;
  logic       ctl_wr;
  assign ctl_wr = cyc_i && stb_i && !ack_o && we_i && adr_i[7:2] == 6'h05 && sel_i[1];
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_take;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_ctl_rd;
    s_take ##0 (!we_i && adr_i[7:2] == 6'h05);
  endsequence
  // Mirror of the two protected bits; protected resets leave it alone.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      skip_ff <= 1'b0;
      xtal_ff <= 1'b0;
    end
    else if (ctl_wr)
    begin
      skip_ff <= dat_i[15];
      xtal_ff <= dat_i[14];
    end
  end
  // Counts cycles without a level change of the receive clock.
  always_ff @(posedge clk_i)
  begin
    rxq_ff <= mac_rx_clk_i;
    if (rst_i || mac_rx_clk_i != rxq_ff)
      idle_ff <= 4'h0;
    else if (idle_ff != 4'hf)
      idle_ff <= idle_ff + 4'h1;
  end
  a_xtal_runs: assert property ((xtal_ff || !deep_suspend_i) |=> crystal_enable_o)
    else $error("crystal stopped");
  a_xtal_gated: assert property ((deep_suspend_i && !xtal_ff) |=> !crystal_enable_o)
    else $error("crystal not gated");
  a_ref_kept: assert property (ethernet_phy_reset_o && skip_ff && $past(skip_ff) |-> analog_ref_on_o)
    else $error("reference off with skip set");
  a_phy_hold_len: assert property ($rose(ethernet_phy_reset_o) && $past(phy_reset_start_i)
    |-> ethernet_phy_reset_o [*8] ##1 !ethernet_phy_reset_o)
    else $error("phy hold length wrong");
  a_ready_low: assert property (s_ctl_rd ##0 (ethernet_phy_reset_o || (config_loading_i
    && $past(config_loading_i))) |=> !dat_o[7])
    else $error("ready high too early");
  a_reserved_zero: assert property (ack_o |-> dat_o[31:16] == 16'h0 && !dat_o[10])
    else $error("reserved bits not zero");
  a_mac_held: assert property (ctl_wr && dat_i[11] |-> ##2 mac_rx_reset_o && mac_tx_reset_o)
    else $error("mac domains not held");
  a_mac_idle: assert property (idle_ff == 4'hf |-> mac_rx_reset_o)
    else $error("mac reset released without clock");
  a_host_resume: assert property (resume_done_i && resume_by_host_i
    |=> !wake_status_clear_o && !wake_enable_clear_o)
    else $error("host resume cleared wake state");
  a_unconf_level: assert property (unconfigured_i [*2] |=> sleep_level_o == 2'h2)
    else $error("suspend field not forced");
  a_level_alias: assert property (sleep_level_o != 2'h1)
    else $error("level one shown");
endmodule : pmc_props
bind pmc_power_mgmt_control pmc_props u_props (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
  .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .phy_reset_start_i, .config_loading_i,
  .deep_suspend_i, .unconfigured_i, .resume_done_i, .resume_by_host_i, .mac_rx_clk_i,
  .ethernet_phy_reset_o, .analog_ref_on_o, .crystal_enable_o, .mac_rx_reset_o,
  .mac_tx_reset_o, .wake_status_clear_o, .wake_enable_clear_o, .sleep_level_o);
`default_nettype wire

// ==== testbench/pmc_power_mgmt_control_tb_top.sv ====
// Self-checking bench for the power management control block.
// Assumes the design with shortened counts and a Wishbone master in this bench.
`timescale 1ns/10ps
`default_nettype none
module pmc_power_mgmt_control_tb_top;
  import pmc_pkg::*;
  typedef struct
  {
    logic [7:0] a; logic [3:0] s; logic [31:0] d; logic [31:0] e; logic [1:0] l;
  } pmc_row_t;
  logic clk_i = 1'b0, rst_i = 1'b1, protected_reset_i = 1'b0;
  logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, ack_o;
  logic [7:0] adr_i = 8'h0;
  logic [3:0] sel_i = 4'h0, ev = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o, rd_q;
  logic config_loading_i = 1'b0, deep_suspend_i = 1'b0, unconfigured_i = 1'b0;
  logic resume_done_i = 1'b0, resume_by_host_i = 1'b0, mac_run = 1'b1, mdiv = 1'b0;
  logic mac_rx_clk_i = 1'b0, mac_tx_clk_i = 1'b0;
  logic ethernet_phy_reset_o, analog_ref_on_o, crystal_enable_o, mac_rx_reset_o;
  logic mac_tx_reset_o, wake_request_o, wake_status_clear_o, wake_enable_clear_o;
  pmc_sleep_t sleep_level_o;
  int num_errors = 0, tests_run = 0;
  pmc_row_t rows[8] = '{
    '{8'h14, 4'hf, 32'hffffffff, 32'h0000ebe0, 2'h3},
    '{8'h14, 4'hf, 32'h00000000, 32'h00000080, 2'h0},
    '{8'h14, 4'h1, 32'h00000020, 32'h000000a0, 2'h0},
    '{8'h14, 4'h1, 32'h0000ff00, 32'h00000080, 2'h0},
    '{8'h14, 4'h2, 32'h00002e40, 32'h00002a80, 2'h0},
    '{8'h14, 4'h3, 32'h00000340, 32'h000003c0, 2'h2},
    '{8'h20, 4'hf, 32'hffffffff, 32'h00000000, 2'h2},
    '{8'h18, 4'hf, 32'h00000000, 32'h00000000, 2'h2}};
  pmc_power_mgmt_control #(.HOLD_CYC(8), .REF_SETTLE_CYC(10), .REF_HOLD_CYC(20),
    .IDLE_CYC(4)) dut (.clk_i, .rst_i, .protected_reset_i, .cyc_i, .stb_i, .we_i, .adr_i,
    .sel_i, .dat_i, .dat_o, .ack_o, .phy_reset_start_i(ev[3]), .config_loading_i,
    .deep_suspend_i, .unconfigured_i, .eee_wake_event_i(ev[0]), .phy_wake_event_i(ev[1]),
    .frame_wake_event_i(ev[2]), .resume_done_i, .resume_by_host_i, .mac_rx_clk_i,
    .mac_tx_clk_i, .ethernet_phy_reset_o, .analog_ref_on_o, .crystal_enable_o,
    .mac_rx_reset_o, .mac_tx_reset_o, .wake_request_o, .wake_status_clear_o,
    .wake_enable_clear_o, .sleep_level_o);
  initial
  begin
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    mdiv <= ~mdiv;
    if (mac_run && mdiv)
    begin
      mac_rx_clk_i <= ~mac_rx_clk_i;
      mac_tx_clk_i <= ~mac_tx_clk_i;
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
    input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= s;
    dat_i <= d;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack_o !== 1'b1);
    chk(32'(n), 32'h2);
    rd_q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask : wb
  task automatic rd(input logic [7:0] a);
    wb(1'b0, a, 4'hf, 32'h0);
  endtask : rd
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick
  task automatic pulse(input logic [3:0] m);
    @(posedge clk_i);
    ev <= m;
    @(posedge clk_i);
    ev <= 4'h0;
  endtask : pulse
  task automatic resume(input logic h);
    @(posedge clk_i);
    resume_done_i <= 1'b1;
    resume_by_host_i <= h;
    @(posedge clk_i);
    resume_done_i <= 1'b0;
    #1;
    chk({30'h0, wake_status_clear_o, wake_enable_clear_o}, h ? 32'h0 : 32'h3);
  endtask : resume
  task automatic complete_run;
    if (num_errors == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run
  initial
  begin
    #100000;
    num_errors++;
    complete_run();
  end
  initial
  begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    tick(40);
    foreach (rows[i])
    begin
      wb(1'b1, rows[i].a, rows[i].s, rows[i].d);
      rd(rows[i].a);
      chk(rd_q, rows[i].e);
      chk({30'h0, sleep_level_o}, {30'h0, rows[i].l});
    end
    tick(20);
    chk({30'h0, mac_rx_reset_o, mac_tx_reset_o}, 32'h0);
    mac_run = 1'b0;
    tick(20);
    chk({30'h0, mac_rx_reset_o, mac_tx_reset_o}, 32'h3);
    mac_run = 1'b1;
    tick(20);
    chk({30'h0, mac_rx_reset_o, mac_tx_reset_o}, 32'h0);
    wb(1'b1, 8'h14, 4'h3, 32'h00000940);
    tick(4);
    chk({30'h0, mac_rx_reset_o, mac_tx_reset_o}, 32'h3);
    wb(1'b1, 8'h14, 4'h3, 32'h00000140);
    pulse(4'h1);
    tick(3);
    chk({31'h0, wake_request_o}, 32'h0);
    rd(8'h14);
    chk(rd_q, 32'h000011c0);
    wb(1'b1, 8'h14, 4'h3, 32'h00002140);
    tick(3);
    chk({31'h0, wake_request_o}, 32'h1);
    wb(1'b1, 8'h14, 4'h3, 32'h00003140);
    rd(8'h14);
    chk(rd_q, 32'h000021c0);
    pulse(4'h6);
    rd(8'h18);
    chk(rd_q, 32'h00000003);
    wb(1'b1, 8'h18, 4'hf, 32'h00000001);
    rd(8'h18);
    chk(rd_q, 32'h00000002);
    wb(1'b1, 8'h14, 4'h3, 32'h00002340);
    pulse(4'h3);
    resume(1'b1);
    rd(8'h14);
    chk(rd_q, 32'h000033c0);
    rd(8'h18);
    chk(rd_q, 32'h00000003);
    resume(1'b0);
    rd(8'h14);
    chk(rd_q, 32'h000003c0);
    rd(8'h18);
    chk(rd_q, 32'h00000001);
    wb(1'b1, 8'h14, 4'h3, 32'h00008140);
    pulse(4'h8);
    tick(2);
    chk({30'h0, ethernet_phy_reset_o, analog_ref_on_o}, 32'h3);
    rd(8'h14);
    chk(rd_q & 32'h80, 32'h0);
    tick(12);
    rd(8'h14);
    chk(rd_q & 32'h80, 32'h80);
    wb(1'b1, 8'h14, 4'h3, 32'h00000140);
    pulse(4'h8);
    tick(2);
    chk({30'h0, ethernet_phy_reset_o, analog_ref_on_o}, 32'h2);
    tick(10);
    chk({31'h0, ethernet_phy_reset_o}, 32'h0);
    rd(8'h14);
    chk(rd_q & 32'h80, 32'h0);
    tick(20);
    rd(8'h14);
    chk(rd_q & 32'h80, 32'h80);
    config_loading_i <= 1'b1;
    rd(8'h14);
    chk(rd_q & 32'h80, 32'h0);
    config_loading_i <= 1'b0;
    tick(2);
    rd(8'h14);
    chk(rd_q & 32'h80, 32'h80);
    wb(1'b1, 8'h14, 4'h3, 32'h0000e960);
    @(posedge clk_i);
    protected_reset_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    protected_reset_i <= 1'b0;
    rd(8'h14);
    chk(rd_q & ~32'h80, 32'h0000c140);
    deep_suspend_i <= 1'b1;
    tick(3);
    chk({31'h0, crystal_enable_o}, 32'h1);
    wb(1'b1, 8'h14, 4'h3, 32'h00000160);
    tick(3);
    chk({31'h0, crystal_enable_o}, 32'h0);
    @(posedge clk_i);
    deep_suspend_i <= 1'b0;
    unconfigured_i <= 1'b1;
    tick(3);
    chk({31'h0, crystal_enable_o}, 32'h1);
    rd(8'h14);
    chk(rd_q & 32'h60, 32'h40);
    chk({30'h0, sleep_level_o}, 32'h2);
    wb(1'b1, 8'h14, 4'h1, 32'h00000040);
    unconfigured_i <= 1'b0;
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h14);
    chk(rd_q, 32'h00000140);
    chk({31'h0, ethernet_phy_reset_o}, 32'h1);
    complete_run();
  end
endmodule : pmc_power_mgmt_control_tb_top
`default_nettype wire
